// ### hw/esc_params.svh
// register offsets, field positions, codes and reset values of the encoder bank
`ifndef ESC_PARAMS_SVH
`define ESC_PARAMS_SVH
// byte offsets on the register bus
`define ESC_STAT_OFS 8'h00
`define ESC_POSH_OFS 8'h04
`define ESC_POSL_OFS 8'h08
`define ESC_POSITION_HOLD_OFS 8'h0C
`define ESC_VEL_OFS 8'h10
`define ESC_IDXH_OFS 8'h14
`define ESC_IDXL_OFS 8'h18
`define ESC_IDXHLD_OFS 8'h1C
`define ESC_ICH_OFS 8'h20
// flag index inside the seven-entry flag vector; status bit is 2*index+1
`define ESC_F_GE 6
`define ESC_F_LE 5
`define ESC_F_POSOV 4
`define ESC_F_HOMING 3
`define ESC_F_VELOV 2
`define ESC_F_HOME 1
`define ESC_F_INDEX 0
`define ESC_NFLAG 7
// position init modes that run the homing sequence
`define ESC_MODE_FIRST 3'b011
`define ESC_MODE_SECOND 3'b100
// bus answers and reset values
`define ESC_RESP_OKAY 2'b00
`define ESC_RESP_SLVERR 2'b10
`define ESC_RST16 16'h0000
`define ESC_RST32 32'h0000_0000
`endif

// ### hw/esc_pkg.sv
// types shared by the encoder status and counter bank
package esc_pkg;
  // decoder events for one clock
  typedef struct packed {
    logic pos_up;
    logic pos_down;
    logic index;
    logic home;
  } enc_evt_t;
  // homing sequence states, one bit changes from IDLE to ARMED to SECOND, both on SECOND back to IDLE
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ARMED = 2'b01,
    H_SECOND = 2'b11
  } home_state_t;
endpackage

// ### hw/encoder_status_counter_bank.sv
// encoder event flags, counters and hold registers behind an axi4-lite slave
`timescale 1ns/1ns
`include "esc_params.svh"

// How it works
// - ge flag set while position >= ge value
// - le flag set while position <= le value
// - position overflow sets its sticky flag
// - homing reload of position sets homing flag
// - homing flag only in modes 011, 100
// - velocity counter overflow sets its flag
// - home event sets home flag
// - index event sets index flag
// - flags hardware set, software cleared, reset zero
// - enable bit below each flag, read/write
// - status bits 15 and 14 read zero
// - position count from high and low words
// - hold register carries position high word
// - sixteen-bit read/write velocity counter
// - index counter with words and hold
// - init value high word register, resets zero
// - mode 011 first, 100 second index loads
module encoder_status_counter_bank
  import esc_pkg::*;
#(
  parameter int VEL_W = 16
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // decoder events and outside values
  input wire enc_evt_t enc_evt,
  input wire logic [2:0] position_init_mode,
  input wire logic [31:0] ge_compare_value,
  input wire logic [31:0] le_compare_value,
  input wire logic [15:0] init_capture_low,
  // axi4-lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // interrupt
  output logic irq
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (VEL_W < 2 || VEL_W > 16)
  begin : g_bad_width
    $error("VEL_W must lie in 2..16");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] position_count;
  logic [15:0] position_hold;
  logic [VEL_W-1:0] velocity_count_value;
  logic [31:0] index_count;
  logic [15:0] index_hold;
  logic [15:0] init_capture_high;
  logic [`ESC_NFLAG-1:0] flags;
  logic [`ESC_NFLAG-1:0] irq_en;
  home_state_t hstate;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [15:0] stat_word;
  logic [15:0] wr16;
  logic homing_load;
  logic pos_step;
  logic pos_ovf_evt;
  logic vel_ovf_evt;
  logic [`ESC_NFLAG-1:0] next_set;
  logic [`ESC_NFLAG-1:0] rd_clear;
  logic [31:0] next_rdata;
  logic rd_hit;

  // byte lane merge for a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------
  // bus strobes
  // ----------------------------------------
  // address and data are taken together, so one fire covers both
  assign wr_fire = awvalid && awready;
  assign rd_fire = arvalid && arready;
  assign wr_addr = awaddr;
  assign wr16 = wdata[15:0];

  // status word, enable sits just below its flag
  always_comb
  begin
    stat_word = `ESC_RST16;
    for (int i = 0; i < `ESC_NFLAG; i++)
    begin
      stat_word[2*i+1] = flags[i];
      stat_word[2*i] = irq_en[i];
    end
    stat_word[15:14] = 2'b00;
  end

  // ----------------------------------------
  // events
  // ----------------------------------------
  // homing load on the chosen index
  assign homing_load = enc_evt.index &&
    ((hstate == H_ARMED && position_init_mode == `ESC_MODE_FIRST) ||
     (hstate == H_SECOND && position_init_mode == `ESC_MODE_SECOND));
  // a step counts only when software or homing does not load the counter
  assign pos_step = !(wr_fire && (wr_addr == `ESC_POSH_OFS || wr_addr == `ESC_POSL_OFS))
    && !homing_load && (enc_evt.pos_up ^ enc_evt.pos_down);
  assign pos_ovf_evt = pos_step &&
    ((enc_evt.pos_up && &position_count) || (enc_evt.pos_down && ~|position_count));
  assign vel_ovf_evt = !(wr_fire && wr_addr == `ESC_VEL_OFS) &&
    ((enc_evt.pos_up && !enc_evt.pos_down && &velocity_count_value) ||
     (enc_evt.pos_down && !enc_evt.pos_up && ~|velocity_count_value));

  always_comb
  begin
    next_set = '0;
    next_set[`ESC_F_GE] = position_count >= ge_compare_value;
    next_set[`ESC_F_LE] = position_count <= le_compare_value;
    next_set[`ESC_F_POSOV] = pos_ovf_evt;
    next_set[`ESC_F_HOMING] = homing_load;
    next_set[`ESC_F_VELOV] = vel_ovf_evt;
    next_set[`ESC_F_HOME] = enc_evt.home;
    next_set[`ESC_F_INDEX] = enc_evt.index;
  end

  assign rd_clear = (rd_fire && araddr == `ESC_STAT_OFS) ? '1 : '0;

  // ----------------------------------------
  // homing sequence
  // ----------------------------------------
  // sequence runs only in modes 011 and 100
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      hstate <= H_IDLE;
    else if (position_init_mode != `ESC_MODE_FIRST && position_init_mode != `ESC_MODE_SECOND)
      hstate <= H_IDLE;
    else
      case (hstate)
        H_IDLE: if (enc_evt.home) hstate <= H_ARMED;
        H_ARMED:
          if (enc_evt.index)
            hstate <= (position_init_mode == `ESC_MODE_SECOND) ? H_SECOND : H_IDLE;
        H_SECOND: if (enc_evt.index) hstate <= H_IDLE;
        default: hstate <= H_IDLE;
      endcase
  end

  // ----------------------------------------
  // flags and enables
  // ----------------------------------------
  // hardware sets, read clears, set wins
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      flags <= '0;
    else
      flags <= (flags & ~rd_clear) | next_set;
  end

  // enables written from even status bits
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      irq_en <= '0;
    else if (wr_fire && wr_addr == `ESC_STAT_OFS)
      for (int i = 0; i < `ESC_NFLAG; i++)
        irq_en[i] <= wstrb[(2*i)/8] ? wdata[2*i] : irq_en[i];
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(flags & irq_en);
  end

  // ----------------------------------------
  // counters
  // ----------------------------------------
  // position words; low write takes hold
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      position_count <= `ESC_RST32;
    else if (wr_fire && wr_addr == `ESC_POSL_OFS)
      position_count <= {position_hold, merge16(position_count[15:0], wdata, wstrb)};
    else if (wr_fire && wr_addr == `ESC_POSH_OFS)
      position_count[31:16] <= merge16(position_count[31:16], wdata, wstrb);
    else if (homing_load)
      position_count <= {init_capture_high, init_capture_low};
    else if (pos_step)
      position_count <= enc_evt.pos_up ? position_count + 32'h0000_0001
                                       : position_count - 32'h0000_0001;
  end

  // hold register; low read latches high
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      position_hold <= `ESC_RST16;
    else if (wr_fire && wr_addr == `ESC_POSITION_HOLD_OFS)
      position_hold <= merge16(position_hold, wdata, wstrb);
    else if (rd_fire && araddr == `ESC_POSL_OFS)
      position_hold <= position_count[31:16];
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      velocity_count_value <= '0;
    else if (wr_fire && wr_addr == `ESC_VEL_OFS)
      velocity_count_value <= VEL_W'(merge16(16'(velocity_count_value), wdata, wstrb));
    else if (enc_evt.pos_up && !enc_evt.pos_down)
      velocity_count_value <= velocity_count_value + VEL_W'(1);
    else if (enc_evt.pos_down && !enc_evt.pos_up)
      velocity_count_value <= velocity_count_value - VEL_W'(1);
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      index_count <= `ESC_RST32;
    else if (wr_fire && wr_addr == `ESC_IDXL_OFS)
      index_count <= {index_hold, merge16(index_count[15:0], wdata, wstrb)};
    else if (wr_fire && wr_addr == `ESC_IDXH_OFS)
      index_count[31:16] <= merge16(index_count[31:16], wdata, wstrb);
    else if (enc_evt.index)
      index_count <= index_count + 32'h0000_0001;
  end

  // index hold; latched on low read
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      index_hold <= `ESC_RST16;
    else if (wr_fire && wr_addr == `ESC_IDXHLD_OFS)
      index_hold <= merge16(index_hold, wdata, wstrb);
    else if (rd_fire && araddr == `ESC_IDXL_OFS)
      index_hold <= index_count[31:16];
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      init_capture_high <= `ESC_RST16;
    else if (wr_fire && wr_addr == `ESC_ICH_OFS)
      init_capture_high <= merge16(init_capture_high, wdata, wstrb);
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  // write: ready pulses once both channels are offered
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `ESC_RESP_OKAY;
    end
    else
    begin
      awready <= !awready && awvalid && wvalid && !bvalid;
      wready <= !awready && awvalid && wvalid && !bvalid;
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= (wr_addr[1:0] == 2'b00 && wr_addr <= `ESC_ICH_OFS) ? `ESC_RESP_OKAY
                                                                    : `ESC_RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // read data mux
  always_comb
  begin
    rd_hit = 1'b1;
    next_rdata = `ESC_RST32;
    case (araddr)
      `ESC_STAT_OFS: next_rdata[15:0] = stat_word;
      `ESC_POSH_OFS: next_rdata[15:0] = position_count[31:16];
      `ESC_POSL_OFS: next_rdata[15:0] = position_count[15:0];
      `ESC_POSITION_HOLD_OFS: next_rdata[15:0] = position_hold;
      `ESC_VEL_OFS: next_rdata[15:0] = 16'(velocity_count_value);
      `ESC_IDXH_OFS: next_rdata[15:0] = index_count[31:16];
      `ESC_IDXL_OFS: next_rdata[15:0] = index_count[15:0];
      `ESC_IDXHLD_OFS: next_rdata[15:0] = index_hold;
      `ESC_ICH_OFS: next_rdata[15:0] = init_capture_high;
      default: rd_hit = 1'b0;
    endcase
  end

  // read: one pulse of arready, data one edge later
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= `ESC_RST32;
      rresp <= `ESC_RESP_OKAY;
      rd_addr <= 8'h00;
    end
    else
    begin
      arready <= !arready && arvalid && !rvalid;
      if (rd_fire)
      begin
        rvalid <= 1'b1;
        rdata <= next_rdata;
        rresp <= rd_hit ? `ESC_RESP_OKAY : `ESC_RESP_SLVERR;
        rd_addr <= araddr;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_second_index;
    enc_evt.index && position_init_mode == `ESC_MODE_SECOND && hstate == H_SECOND;
  endsequence
  sequence s_first_index;
    enc_evt.index && position_init_mode == `ESC_MODE_FIRST && hstate == H_ARMED;
  endsequence

  AST_GE_SET: assert property (position_count >= ge_compare_value |=> flags[`ESC_F_GE])
    else $error("ge flag missed");
  AST_LE_SET: assert property (position_count <= le_compare_value |=> flags[`ESC_F_LE])
    else $error("le flag missed");
  AST_POS_OVF: assert property (pos_step && enc_evt.pos_up && &position_count
    |=> flags[`ESC_F_POSOV] && position_count == 32'h0000_0000)
    else $error("position overflow missed");
  AST_HOMING_LOAD: assert property (homing_load |=> flags[`ESC_F_HOMING]
    && position_count[31:16] == $past(init_capture_high))
    else $error("homing reload wrong");
  AST_HOMING_MODE: assert property ($rose(flags[`ESC_F_HOMING]) |->
    $past(position_init_mode) inside {`ESC_MODE_FIRST, `ESC_MODE_SECOND})
    else $error("homing flag in wrong mode");
  AST_VEL_OVF: assert property (vel_ovf_evt |=> flags[`ESC_F_VELOV])
    else $error("velocity overflow missed");
  AST_HOME_FLAG: assert property (enc_evt.home |=> flags[`ESC_F_HOME])
    else $error("home flag missed");
  AST_INDEX_FLAG: assert property (enc_evt.index |=> flags[`ESC_F_INDEX] ##0
    index_count != $past(index_count))
    else $error("index flag missed");
  AST_NO_SW_SET: assert property ($rose(flags[`ESC_F_HOME]) |-> $past(enc_evt.home))
    else $error("home flag set without event");
  AST_RSV_ZERO: assert property (rvalid && rd_addr == `ESC_STAT_OFS |-> rdata[15:14] == 2'b00)
    else $error("reserved status bits nonzero");
  AST_MODE_FIRST: assert property (s_first_index |=> flags[`ESC_F_HOMING]
    && position_count[15:0] == $past(init_capture_low))
    else $error("first index after home did not load");
  AST_MODE_SECOND: assert property (s_second_index |=> flags[`ESC_F_HOMING]
    && position_count[15:0] == $past(init_capture_low))
    else $error("second index after home did not load");
  AST_IRQ: assert property (|(flags & irq_en) |=> irq)
    else $error("interrupt not raised");
  AST_HOLD_LATCH: assert property (rd_fire && araddr == `ESC_POSL_OFS && !wr_fire
    |=> position_hold == $past(position_count[31:16]))
    else $error("position hold not latched");

endmodule // encoder_status_counter_bank

// ### bench/enc_model.sv
// encoder-side model: turns bench requests into decoded one-cycle event pulses
`timescale 1ns/1ns
module enc_model
  import esc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // bench request, same bit order as the event struct
  input wire logic [3:0] req,
  // decoded events toward the bank
  output enc_evt_t enc_evt
);
  // one registered pulse per request, quiet while in reset
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      enc_evt <= '0;
    else
      enc_evt <= enc_evt_t'(req);
  end
endmodule // enc_model

// ### bench/encoder_status_counter_bank_tb.sv
// self-checking bench for the encoder status and counter bank
`timescale 1ns/1ns
`include "esc_params.svh"
module encoder_status_counter_bank_tb;
  logic clk_sys, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [3:0] req, wstrb;
  logic [2:0] position_init_mode;
  logic [31:0] ge_compare_value, le_compare_value, wdata, rdata, rd_val;
  logic [15:0] init_capture_low;
  logic [7:0] awaddr, araddr;
  logic [1:0] bresp, rresp;
  esc_pkg::enc_evt_t enc_evt;
  int bad_count, tests_run, cyc;
  logic [2:0] modes [3] = '{3'b000, 3'b011, 3'b100};
  int idx_n [3] = '{1, 1, 2};
  logic [31:0] cmp_pos [3] = '{32'h0000_0010, 32'h0000_0011, 32'h0000_000F};
  logic [31:0] cmp_exp [3] = '{32'h0000_2800, 32'h0000_2000, 32'h0000_0800};

  // ----------------------------------------
  // design, encoder model, clock and watchdog
  // ----------------------------------------
  encoder_status_counter_bank encoder_status_counter_bank_i (
    .clk_sys(clk_sys), .nrst(nrst), .enc_evt(enc_evt),
    .position_init_mode(position_init_mode), .ge_compare_value(ge_compare_value),
    .le_compare_value(le_compare_value), .init_capture_low(init_capture_low),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq(irq));
  enc_model enc_model_i (.clk_sys(clk_sys), .nrst(nrst), .req(req), .enc_evt(enc_evt));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // a hang counts as a mismatch
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  // ----------------------------------------
  // compare, bus and event tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  // axi4-lite write, response checked against the address map
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, (a > 8'h20) ? `ESC_RESP_SLVERR : `ESC_RESP_OKAY});
  endtask

  // axi4-lite read, data taken at the edge that sees rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    v = rdata;
    chk({30'h0, rresp}, {30'h0, (a > 8'h20) ? `ESC_RESP_SLVERR : `ESC_RESP_OKAY});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, rd_val);
    chk(rd_val & m, e);
  endtask

  // one event pulse, then time for flag and irq to settle
  task automatic ev(input logic [3:0] r);
    @(posedge clk_sys);
    req <= r;
    @(posedge clk_sys);
    req <= 4'h0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, req} = '0;
    wstrb = 4'hF;
    position_init_mode = 3'b000;
    ge_compare_value = 32'h7FFF_FFFF;
    le_compare_value = 32'h0000_0000;
    init_capture_low = 16'h1234;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    // reset values, unmapped place
    for (int i = 1; i <= 8; i++)
      rchk(8'(4 * i), 32'hFFFF_FFFF, 32'h0000_0000);
    rchk(`ESC_STAT_OFS, 32'hFFFF_F7FF, 32'h0000_0000);
    rchk(8'h24, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h24, 32'h0000_FFFF);
    // position words through the hold register
    wr(`ESC_POSITION_HOLD_OFS, 32'h0000_0001);
    wr(`ESC_POSL_OFS, 32'h0000_0000);
    rchk(`ESC_POSH_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
    wr(`ESC_POSITION_HOLD_OFS, 32'h0000_0000);
    rchk(`ESC_POSL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk(`ESC_POSITION_HOLD_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
    rd(`ESC_STAT_OFS, rd_val);
    rchk(`ESC_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    // enables writable, flags and top bits not
    wr(`ESC_STAT_OFS, 32'h0000_FFFF);
    rchk(`ESC_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_1555);
    chk({31'h0, irq}, 32'h0000_0000);
    // home event raises irq, status read clears it
    ev(4'h1);
    chk({31'h0, irq}, 32'h0000_0001);
    rchk(`ESC_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_155D);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0000);
    rchk(`ESC_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_1555);
    // masked index event and index counter
    wr(`ESC_STAT_OFS, 32'h0000_0000);
    ev(4'h2);
    chk({31'h0, irq}, 32'h0000_0000);
    rchk(`ESC_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0002);
    rchk(`ESC_IDXL_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
    rchk(`ESC_IDXHLD_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    // velocity wraps, position steps
    wr(`ESC_VEL_OFS, 32'h0000_FFFF);
    ev(4'h8);
    rchk(`ESC_VEL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk(`ESC_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0020);
    rchk(`ESC_POSL_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
    // position overflow from all ones
    wr(`ESC_POSITION_HOLD_OFS, 32'h0000_FFFF);
    wr(`ESC_POSL_OFS, 32'h0000_FFFF);
    ev(4'h8);
    rchk(`ESC_STAT_OFS, 32'h0000_0200, 32'h0000_0200);
    rchk(`ESC_POSL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    // downward wrap, opposed steps, velocity underflow
    ev(4'h4);
    rchk(`ESC_STAT_OFS, 32'h0000_0220, 32'h0000_0200);
    ev(4'hC);
    rchk(`ESC_POSL_OFS, 32'hFFFF_FFFF, 32'h0000_FFFF);
    ev(4'h4);
    rchk(`ESC_STAT_OFS, 32'h0000_0220, 32'h0000_0020);
    rchk(`ESC_VEL_OFS, 32'hFFFF_FFFF, 32'h0000_FFFF);
    // compare bounds at, above and below
    ge_compare_value <= 32'h0000_0010;
    le_compare_value <= 32'h0000_0010;
    for (int k = 0; k < 3; k++)
    begin
      wr(`ESC_POSITION_HOLD_OFS, 32'h0000_0000);
      wr(`ESC_POSL_OFS, cmp_pos[k]);
      rd(`ESC_STAT_OFS, rd_val);
      rchk(`ESC_STAT_OFS, 32'h0000_2800, cmp_exp[k]);
    end
    // homing loads in modes 011 and 100 only
    wr(`ESC_ICH_OFS, 32'h0000_ABCD);
    rchk(`ESC_ICH_OFS, 32'hFFFF_FFFF, 32'h0000_ABCD);
    for (int k = 0; k < 3; k++)
    begin
      position_init_mode <= modes[k];
      wr(`ESC_POSITION_HOLD_OFS, 32'h0000_0000);
      wr(`ESC_POSL_OFS, 32'h0000_0000);
      rd(`ESC_STAT_OFS, rd_val);
      ev(4'h1);
      for (int i = 0; i < idx_n[k]; i++)
      begin
        ev(4'h2);
        if (i < idx_n[k] - 1)
          rchk(`ESC_POSL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
      end
      rchk(`ESC_POSL_OFS, 32'hFFFF_FFFF, (k > 0) ? 32'h0000_1234 : 32'h0000_0000);
      rchk(`ESC_POSITION_HOLD_OFS, 32'hFFFF_FFFF, (k > 0) ? 32'h0000_ABCD : 32'h0000_0000);
      rchk(`ESC_STAT_OFS, 32'h0000_0080, (k > 0) ? 32'h0000_0080 : 32'h0000_0000);
    end
    close_out();
  end
endmodule // encoder_status_counter_bank_tb
